// ===== rtl/sdiioc_defs.vh
`ifndef SDIIOC_DEFS_VH
`define SDIIOC_DEFS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SDIIOC_ADDR_GENERAL_CONTROL      7'h00
`define SDIIOC_ADDR_OUTPUT_DRIVER_SETUP  7'h01

// ------------------------------------------------------------
// general_control fields
// ------------------------------------------------------------
`define SDIIOC_GC_CARRIER_BIT            7
`define SDIIOC_GC_MUTE_BIT               6
`define SDIIOC_GC_SLEEP_HI               4
`define SDIIOC_GC_SLEEP_LO               3
`define SDIIOC_GC_EXT_REACH_BIT          2
`define SDIIOC_GC_MUTE_RST               1'b0
`define SDIIOC_GC_SLEEP_RST              2'h1
`define SDIIOC_GC_EXT_REACH_RST          1'b0

// ------------------------------------------------------------
// Sleep mode codes
// ------------------------------------------------------------
`define SDIIOC_SLEEP_NEVER               2'h0
`define SDIIOC_SLEEP_AUTO                2'h1
`define SDIIOC_SLEEP_FORCE               2'h2

// ------------------------------------------------------------
// output_driver_setup fields
// ------------------------------------------------------------
`define SDIIOC_OD_SWING_HI               7
`define SDIIOC_OD_SWING_LO               5
`define SDIIOC_OD_CML_HI                 4
`define SDIIOC_OD_CML_LO                 2
`define SDIIOC_OD_SWING_RST              3'h3
`define SDIIOC_OD_CML_RST                3'h1

// ------------------------------------------------------------
// Serial frame
// ------------------------------------------------------------
`define SDIIOC_HDR_BITS                  5'h08
`define SDIIOC_FRAME_BITS                5'h10
`define SDIIOC_RD_DATA_NONE              8'h00

`endif

// ===== rtl/sdiioc_sync.v
`timescale 1ns/1ps

// ------------------------------------------------------------
// Two-stage synchroniser, one chain per bit
// ------------------------------------------------------------
module sdiioc_sync #(
  parameter W       = 9,
  parameter RST_VAL = 9'h000
) (
  input  wire         i_mclk,
  input  wire         i_sys_rst,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
      always @(posedge i_mclk) begin
        if (i_sys_rst) begin
          stage1[gi] <= RST_VAL[gi];
          stage2[gi] <= RST_VAL[gi];
        end else begin
          stage1[gi] <= i_async[gi];
          stage2[gi] <= stage1[gi];
        end
      end
    end
  endgenerate

  assign o_sync = stage2;

endmodule // sdiioc_sync

// ===== rtl/sdiioc_regs.v
`timescale 1ns/1ps
`include "sdiioc_defs.vh"

module sdiioc_regs (
  input  wire       i_mclk,
  input  wire       i_sys_rst,
  input  wire       i_spi_en,
  input  wire       i_spi_sck,
  input  wire       i_spi_ss_n,
  input  wire       i_spi_mosi,
  output reg        o_spi_miso,
  output reg        o_spi_miso_oe,
  input  wire       i_carrier_detect,
  input  wire       i_edge_rate_select,
  input  wire       i_edge_rate_select_drv,
  input  wire       i_line_drv_en,
  input  wire       i_line_drv_en_drv,
  output reg        o_slow_edge,
  output reg        o_cable_drv_on,
  output reg        o_eq_powered,
  output reg        o_eq_mute,
  output reg        o_eq_ext_reach,
  output reg  [2:0] o_output_swing_level,
  output reg  [2:0] o_common_mode_level
);

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  wire [8:0] pins_sync;
  wire       spi_en_s;
  wire       sck_s;
  wire       ss_n_s;
  wire       mosi_s;
  wire       carrier_s;
  wire       edge_sel_s;
  wire       edge_drv_s;
  wire       txen_s;
  wire       txen_drv_s;

  sdiioc_sync #(
    .W       (9),
    .RST_VAL (9'h004)
  ) u_sync (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_line_drv_en_drv, i_line_drv_en, i_edge_rate_select_drv,
                 i_edge_rate_select, i_carrier_detect, i_spi_mosi,
                 i_spi_ss_n, i_spi_sck, i_spi_en}),
    .o_sync    (pins_sync)
  );

  assign spi_en_s   = pins_sync[0];
  assign sck_s      = pins_sync[1];
  assign ss_n_s     = pins_sync[2];
  assign mosi_s     = pins_sync[3];
  assign carrier_s  = pins_sync[4];
  assign edge_sel_s = pins_sync[5];
  assign edge_drv_s = pins_sync[6];
  assign txen_s     = pins_sync[7];
  assign txen_drv_s = pins_sync[8];

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  reg        mute;
  reg  [1:0] sleep_mode;
  reg        ext_reach;
  reg  [2:0] swing;
  reg  [2:0] cml;

  wire [7:0] gc_read;
  wire [7:0] od_read;

  assign gc_read = {carrier_s, mute, 1'b0, sleep_mode, ext_reach, 2'b00};
  assign od_read = {swing, cml, 2'b00};

  // ------------------------------------------------------------
  // Serial port
  // ------------------------------------------------------------
  reg        sck_d;
  reg        mosi_d;
  reg  [4:0] bit_cnt;
  reg  [6:0] shift_in;
  reg  [6:0] frame_addr;
  reg        frame_read;
  reg  [7:0] shift_out;
  reg  [7:0] next_rd_data;
  reg        wr_stb;
  reg  [7:0] wr_data;

  wire       sck_rise;
  wire       sck_fall;
  wire       active;
  wire [7:0] rx_byte;

  assign active   = spi_en_s & ~ss_n_s;
  assign sck_rise = active & sck_s & ~sck_d;
  assign sck_fall = active & ~sck_s & sck_d;
  // Data bit from before the edge; host may change it right at the edge
  assign rx_byte  = {shift_in, mosi_d};

  always @* begin
    case (rx_byte[6:0])
      `SDIIOC_ADDR_GENERAL_CONTROL:     next_rd_data = gc_read;
      `SDIIOC_ADDR_OUTPUT_DRIVER_SETUP: next_rd_data = od_read;
      default:                          next_rd_data = `SDIIOC_RD_DATA_NONE;
    endcase
  end

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sck_d         <= 1'b0;
      mosi_d        <= 1'b0;
      bit_cnt       <= 5'h00;
      shift_in      <= 7'h00;
      frame_addr    <= 7'h00;
      frame_read    <= 1'b0;
      shift_out     <= 8'h00;
      wr_stb        <= 1'b0;
      wr_data       <= 8'h00;
      o_spi_miso    <= 1'b0;
      o_spi_miso_oe <= 1'b0;
    end else begin
      sck_d  <= sck_s;
      mosi_d <= mosi_s;
      wr_stb <= 1'b0;
      if (!active) begin
        bit_cnt       <= 5'h00;
        frame_read    <= 1'b0;
        o_spi_miso_oe <= 1'b0;
      end else begin
        if (sck_rise && bit_cnt < `SDIIOC_FRAME_BITS) begin
          shift_in <= rx_byte[6:0];
          bit_cnt  <= bit_cnt + 5'h01;
          if (bit_cnt == `SDIIOC_HDR_BITS - 5'h01) begin
            frame_read <= rx_byte[7];
            frame_addr <= rx_byte[6:0];
            if (rx_byte[7]) begin
              shift_out <= next_rd_data;
            end
          end
          if (bit_cnt == `SDIIOC_FRAME_BITS - 5'h01 && !frame_read) begin
            wr_stb  <= 1'b1;
            wr_data <= rx_byte;
          end
        end
        if (sck_fall && frame_read && bit_cnt >= `SDIIOC_HDR_BITS) begin
          o_spi_miso    <= shift_out[7];
          o_spi_miso_oe <= 1'b1;
          shift_out     <= {shift_out[6:0], 1'b0};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      mute       <= `SDIIOC_GC_MUTE_RST;
      sleep_mode <= `SDIIOC_GC_SLEEP_RST;
      ext_reach  <= `SDIIOC_GC_EXT_REACH_RST;
      swing      <= `SDIIOC_OD_SWING_RST;
      cml        <= `SDIIOC_OD_CML_RST;
    end else if (wr_stb) begin
      if (frame_addr == `SDIIOC_ADDR_GENERAL_CONTROL) begin
        // Carrier bit and reserved bits are dropped
        mute       <= wr_data[`SDIIOC_GC_MUTE_BIT];
        sleep_mode <= wr_data[`SDIIOC_GC_SLEEP_HI:`SDIIOC_GC_SLEEP_LO];
        ext_reach  <= wr_data[`SDIIOC_GC_EXT_REACH_BIT];
      end
      if (frame_addr == `SDIIOC_ADDR_OUTPUT_DRIVER_SETUP) begin
        swing <= wr_data[`SDIIOC_OD_SWING_HI:`SDIIOC_OD_SWING_LO];
        cml   <= wr_data[`SDIIOC_OD_CML_HI:`SDIIOC_OD_CML_LO];
      end
    end
  end

  // ------------------------------------------------------------
  // Equalizer and driver controls
  // ------------------------------------------------------------
  reg next_powered;

  always @* begin
    case (sleep_mode)
      `SDIIOC_SLEEP_NEVER: next_powered = 1'b1;
      `SDIIOC_SLEEP_AUTO:  next_powered = carrier_s;
      `SDIIOC_SLEEP_FORCE: next_powered = 1'b0;
      default:             next_powered = carrier_s;
    endcase
  end

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_slow_edge          <= 1'b0;
      o_cable_drv_on       <= 1'b1;
      o_eq_powered         <= 1'b0;
      o_eq_mute            <= 1'b0;
      o_eq_ext_reach       <= 1'b0;
      o_output_swing_level <= `SDIIOC_OD_SWING_RST;
      o_common_mode_level  <= `SDIIOC_OD_CML_RST;
    end else begin
      o_slow_edge          <= edge_drv_s & edge_sel_s;
      o_cable_drv_on       <= ~txen_drv_s | txen_s;
      o_eq_powered         <= next_powered;
      o_eq_mute            <= next_powered & mute;
      o_eq_ext_reach       <= ext_reach;
      o_output_swing_level <= swing;
      o_common_mode_level  <= cml;
    end
  end

endmodule // sdiioc_regs

// ===== dv/sdiioc_regs_assertions.sv
`timescale 1ns/1ps
module sdiioc_regs_chk (
  input logic       i_mclk,
  input logic       i_sys_rst,
  input logic       i_spi_ss_n,
  input logic       i_carrier_detect,
  input logic       i_edge_rate_select,
  input logic       i_edge_rate_select_drv,
  input logic       i_line_drv_en,
  input logic       i_line_drv_en_drv,
  input logic       o_spi_miso_oe,
  input logic       o_slow_edge,
  input logic       o_cable_drv_on,
  input logic       o_eq_powered,
  input logic       o_eq_mute,
  input logic       o_eq_ext_reach,
  input logic [2:0] o_output_swing_level,
  input logic [2:0] o_common_mode_level
);
  // ------------------------------------------------
  // Cycles since reset, quiet cycles outside frames
  // ------------------------------------------------
  logic [2:0] up;
  logic [3:0] quiet;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      up <= 3'h0;
      quiet <= 4'h0;
    end else begin
      up <= (up == 3'h7) ? up : up + 3'h1;
      quiet <= (!i_spi_ss_n || $changed(i_carrier_detect)) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
    end
  end
  slow_edge_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    up > 3'h3 |-> o_slow_edge == ($past(i_edge_rate_select, 3) && $past(i_edge_rate_select_drv, 3)))
    else $error("slow edge output wrong");
  drv_on_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    up > 3'h3 |-> o_cable_drv_on == ($past(i_line_drv_en, 3) || !$past(i_line_drv_en_drv, 3)))
    else $error("cable driver power wrong");
  sleep_mute_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst) o_eq_mute |-> o_eq_powered)
    else $error("mute while asleep");
  miso_off_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst) i_spi_ss_n [*8] |-> !o_spi_miso_oe)
    else $error("miso driven outside frame");
  miso_on_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst) $rose(o_spi_miso_oe) |-> !$past(i_spi_ss_n, 4))
    else $error("miso enabled without select");
  reset_val_a: assert property (@(posedge i_mclk) i_sys_rst |=> o_cable_drv_on && !o_eq_mute && !o_eq_ext_reach
    && o_output_swing_level == 3'h3 && o_common_mode_level == 3'h1) else $error("reset values wrong");
  cfg_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst) quiet > 4'h5 |-> $stable(o_eq_ext_reach)
    && $stable(o_output_swing_level) && $stable(o_common_mode_level)) else $error("setup changed without frame");
  pwr_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    quiet > 4'h5 |-> $stable(o_eq_powered) && $stable(o_eq_mute)) else $error("power changed without cause");
  cover property (@(posedge i_mclk) $rose(o_spi_miso_oe));
  cover property (@(posedge i_mclk) o_eq_mute);
  cover property (@(posedge i_mclk) $fell(o_eq_powered));
endmodule // sdiioc_regs_chk

bind sdiioc_regs sdiioc_regs_chk u_chk (
  .i_mclk                 (i_mclk),
  .i_sys_rst              (i_sys_rst),
  .i_spi_ss_n             (i_spi_ss_n),
  .i_carrier_detect       (i_carrier_detect),
  .i_edge_rate_select     (i_edge_rate_select),
  .i_edge_rate_select_drv (i_edge_rate_select_drv),
  .i_line_drv_en          (i_line_drv_en),
  .i_line_drv_en_drv      (i_line_drv_en_drv),
  .o_spi_miso_oe          (o_spi_miso_oe),
  .o_slow_edge            (o_slow_edge),
  .o_cable_drv_on         (o_cable_drv_on),
  .o_eq_powered           (o_eq_powered),
  .o_eq_mute              (o_eq_mute),
  .o_eq_ext_reach         (o_eq_ext_reach),
  .o_output_swing_level   (o_output_swing_level),
  .o_common_mode_level    (o_common_mode_level)
);

// ===== dv/sdiioc_host.sv
`timescale 1ns/1ps
module sdiioc_host (
  output logic o_sck,
  output logic o_ss_n,
  output logic o_mosi,
  input  logic i_miso
);
  initial begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
  end
  // ------------------------------------------------
  // One 16-bit frame, MSB first, 160 ns clock
  // ------------------------------------------------
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    o_ss_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = (f[15] && i < 8) ? ~o_mosi : f[i];
      #80 o_sck = 1'b1;
      if (i < 8) rd[i] = i_miso;
      if (f[15] && i == 8) o_mosi = ~o_mosi;
      #80 o_sck = 1'b0;
    end
    o_mosi = ~o_mosi;
    o_ss_n = 1'b1;
    #400;
  endtask
endmodule // sdiioc_host

// ===== dv/tb_sdiioc_regs.sv
`timescale 1ns/1ps
module tb_sdiioc_regs;
  logic i_mclk, i_sys_rst, i_spi_en, i_spi_sck, i_spi_ss_n, i_spi_mosi, o_spi_miso, o_spi_miso_oe;
  logic i_carrier_detect, i_edge_rate_select, i_edge_rate_select_drv, i_line_drv_en, i_line_drv_en_drv;
  logic o_slow_edge, o_cable_drv_on, o_eq_powered, o_eq_mute, o_eq_ext_reach, p;
  logic [2:0] o_output_swing_level, o_common_mode_level;
  int errors, comparisons;
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  sdiioc_regs u_dut (
    .i_mclk                 (i_mclk),
    .i_sys_rst              (i_sys_rst),
    .i_spi_en               (i_spi_en),
    .i_spi_sck              (i_spi_sck),
    .i_spi_ss_n             (i_spi_ss_n),
    .i_spi_mosi             (i_spi_mosi),
    .o_spi_miso             (o_spi_miso),
    .o_spi_miso_oe          (o_spi_miso_oe),
    .i_carrier_detect       (i_carrier_detect),
    .i_edge_rate_select     (i_edge_rate_select),
    .i_edge_rate_select_drv (i_edge_rate_select_drv),
    .i_line_drv_en          (i_line_drv_en),
    .i_line_drv_en_drv      (i_line_drv_en_drv),
    .o_slow_edge            (o_slow_edge),
    .o_cable_drv_on         (o_cable_drv_on),
    .o_eq_powered           (o_eq_powered),
    .o_eq_mute              (o_eq_mute),
    .o_eq_ext_reach         (o_eq_ext_reach),
    .o_output_swing_level   (o_output_swing_level),
    .o_common_mode_level    (o_common_mode_level)
  );
  sdiioc_host u_host (.o_sck(i_spi_sck), .o_ss_n(i_spi_ss_n), .o_mosi(i_spi_mosi),
    .i_miso(o_spi_miso_oe ? o_spi_miso : ~o_spi_miso));
  // ------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_host.xfer({1'b0, a, d}, x);
  endtask
  task automatic rdc(input string n, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] x;
    u_host.xfer({1'b1, a, 8'h00}, x);
    chk(n, e, x);
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    complete_run;
  end
  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    errors = 0;
    comparisons = 0;
    i_sys_rst = 1'b1;
    i_spi_en = 1'b1;
    i_carrier_detect = 1'b1;
    {i_edge_rate_select, i_edge_rate_select_drv, i_line_drv_en, i_line_drv_en_drv} = 4'h1;
    repeat (20) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    repeat (8) @(negedge i_mclk);
    rdc("gc_rst", 7'h00, 8'h88);
    rdc("od_rst", 7'h01, 8'h64);
    $display("test reset done");
    @(negedge i_mclk) i_carrier_detect = 1'b0;
    wr(7'h00, 8'hdc);
    rdc("gc_ro", 7'h00, 8'h5c);
    chk("ext", {7'h0, 1'b1}, {7'h0, o_eq_ext_reach});
    for (int s = 0; s < 6; s++) begin
      @(negedge i_mclk) i_carrier_detect = s[0];
      wr(7'h00, {3'b010, s[2:1], 3'b000});
      repeat (8) @(negedge i_mclk);
      p = s[2:1] == 2'b00 || (s[2:1] == 2'b01 && s[0]);
      chk("pwr", {7'h0, p}, {7'h0, o_eq_powered});
      chk("mute", {7'h0, p}, {7'h0, o_eq_mute});
    end
    $display("test sleep done");
    for (int k = 0; k < 6; k++) begin
      wr(7'h01, {k[2:0], k[2:0], 2'b00});
      rdc("od", 7'h01, {k[2:0], k[2:0], 2'b00});
      chk("sw_cm", {2'h0, k[2:0], k[2:0]}, {2'h0, o_output_swing_level, o_common_mode_level});
    end
    wr(7'h05, 8'hff);
    rdc("unmapped", 7'h05, 8'h00);
    @(negedge i_mclk) i_spi_en = 1'b0;
    wr(7'h01, 8'h00);
    @(negedge i_mclk) i_spi_en = 1'b1;
    rdc("en_off", 7'h01, 8'hb4);
    $display("test serial done");
    for (int q = 0; q < 16; q++) begin
      @(negedge i_mclk);
      {i_edge_rate_select, i_edge_rate_select_drv, i_line_drv_en, i_line_drv_en_drv} = q[3:0];
      repeat (8) @(negedge i_mclk);
      chk("slow", {7'h0, q[3] & q[2]}, {7'h0, o_slow_edge});
      chk("drv_on", {7'h0, q[1] | !q[0]}, {7'h0, o_cable_drv_on});
    end
    $display("test pins done");
    complete_run;
  end
endmodule // tb_sdiioc_regs
